// >>> src/fcc_forwarder.sv
// frame forwarder with forward-pressure copy limits and four-sheet
// congestion accounting; analyzer upstream, egress queues downstream,
// egress releases resources with rel_valid; one synchronous clock
//
// How it works
// - one copy resolved per clock when rel_valid is low, 200 MHz exceeds 78 M frames/s
// - queue above threshold limits copies per frame; surplus discarded
// - one common counter counts forward-pressure discards of all ports
// - per-port ingress queue size is reported as an output
// - destination mask bit per front port requests a switched copy
// - cpu, mirror, first-link learn copies go through a 12-entry translation table
// - eight cpu queues each map to any port via the table
// - cpu copy qos follows ingress or is fixed; super priority option
// - mirror field is probe 1..3, each with own port and qos
// - learn-all copies to first stack link, plus second when enabled
// - disabled cpu queues never get a copy
// - setting decides whether a discarded frame still mirrors
// - congested copy is discarded in drop mode, else blocks the queue
// - drop mode allows discard on flow-control port; dp 0..3 travels
// - accounts update when the reference enters an egress queue
// - four sheets: ingress/egress words and ingress/egress references
// - pool is 5952 words and 5952 references
// - accounts consumed in order: port-qos, port, qos share, shared
// - admit if account not full before add; excess spills onward
// - separate ingress word sheet drives pfc pause per port
// - allow if (in or eg memory ok) and (in or eg reference ok)
// - shared accounts checked only when reservations are closed
// - drop mode from ingress port, egress port or analyzer flag
module fcc_forwarder #(
	parameter int NPORT = `FCC_NPORT
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic frm_valid,
	input wire fcc_pkg::fcc_frame_type frm,
	output logic frm_ready,
	output logic enq_valid,
	output fcc_pkg::fcc_enq_type enq,
	output logic blocked,
	input wire logic rel_valid,
	input wire fcc_pkg::fcc_rel_type rel,
	input wire logic [NPORT-1:0] iq_push,
	output logic [`FCC_IQ_W-1:0] ingress_queue_size [NPORT],
	input wire fcc_pkg::fcc_limit_type copy_limit_cfg [NPORT],
	output logic [`FCC_DROPCNT_W-1:0] copy_limit_discard_count,
	input wire fcc_pkg::fcc_xlate_type xlate_cfg [`FCC_XLAT_N],
	input wire logic extra_stack_en,
	input wire logic [`FCC_PORT_W-1:0] extra_stack_port,
	input wire logic [`FCC_NCPUQ-1:0] cpu_queue_disable,
	input wire logic mirror_on_discard,
	input wire logic [NPORT-1:0] drop_port_in,
	input wire logic [NPORT-1:0] drop_port_eg,
	input wire fcc_pkg::fcc_acct_type thr_cfg [4],
	input wire fcc_pkg::fcc_cnt_type pfc_thr,
	output logic [NPORT-1:0] pfc_pause
);
	import fcc_pkg::*;
	localparam int TOT = NPORT + `FCC_XLAT_N + 1;
	localparam int NQ = `FCC_NQOS;

	////////////////////////////////////////////////////////////////////
	// account helpers
	// fill accounts in order, the last one takes whatever remains
	function automatic fcc_acct_type acct_add(fcc_acct_type c,
		fcc_acct_type l, fcc_cnt_type a);
		fcc_cnt_type room;
		fcc_cnt_type take;
		room = '0;
		take = '0;
		for (int i = 0; i < 3; i++) begin
			room = (c[i] < l[i]) ? fcc_cnt_type'(l[i] - c[i]) : '0;
			take = (a < room) ? a : room;
			c[i] = fcc_cnt_type'(c[i] + take);
			a = fcc_cnt_type'(a - take);
		end
		c[3] = fcc_cnt_type'(c[3] + a);
		return c;
	endfunction

	// give back from the last account first
	function automatic fcc_acct_type acct_sub(fcc_acct_type c,
		fcc_cnt_type a);
		fcc_cnt_type take;
		take = '0;
		for (int i = 3; i >= 0; i--) begin
			take = (a < c[i]) ? a : c[i];
			c[i] = fcc_cnt_type'(c[i] - take);
			a = fcc_cnt_type'(a - take);
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////
	// frame engine state
	fcc_frame_type cur_r;
	logic busy_r, limit_on_r, discarded_r, first_r;
	logic [TOT-1:0] pend_r, pend_nxt, take_pend;
	logic [`FCC_LIM_W-1:0] copies_r, lim_max_r;
	logic [NPORT-1:0] done_vec;

	// current copy decode
	int sel;
	logic [`FCC_PORT_W-1:0] c_port;
	logic [`FCC_QOS_W-1:0] c_qos;
	logic [3:0] sheet_ok;
	logic any_pend, c_sp, is_mirror, drop_m, limit_hit, mirror_kill;
	logic allowed, step, do_enq, do_lim, do_drop, stall, take, frame_done;

	assign take = frm_valid && frm_ready;

	// pending copies of a new frame
	always_comb begin
		take_pend = '0;
		take_pend[NPORT-1:0] = frm.dest_mask;
		take_pend[NPORT +: `FCC_NCPUQ] =
			frm.cpu_queue_mask & ~cpu_queue_disable;
		if (frm.mirror != '0)
			take_pend[NPORT + `FCC_XL_MIRROR - 1 + int'(frm.mirror)] = 1'b1;
		take_pend[NPORT + `FCC_XL_LEARN] = frm.learn_all;
		take_pend[NPORT + `FCC_XL_EXTRA] =
			frm.learn_all && extra_stack_en;
	end

	// lowest pending copy is handled this cycle
	always_comb begin
		sel = 0;
		any_pend = 1'b0;
		for (int i = TOT - 1; i >= 0; i--) begin
			if (pend_r[i]) begin
				sel = i;
				any_pend = 1'b1;
			end
		end
	end

	// translate the copy into egress port and qos
	always_comb begin
		c_port = `FCC_PORT_W'(sel);
		c_qos = cur_r.qos;
		c_sp = 1'b0;
		is_mirror = 1'b0;
		if (sel == NPORT + `FCC_XL_EXTRA) begin
			c_port = extra_stack_port;
		end else if (sel >= NPORT) begin
			c_port = xlate_cfg[sel - NPORT].port;
			c_sp = xlate_cfg[sel - NPORT].super_prio;
			if (!(sel < NPORT + `FCC_NCPUQ &&
				xlate_cfg[sel - NPORT].follow_qos))
				c_qos = xlate_cfg[sel - NPORT].qos;
			is_mirror = (sel >= NPORT + `FCC_XL_MIRROR) &&
				(sel < NPORT + `FCC_XL_LEARN);
		end
	end

	// decide the fate of the current copy
	always_comb begin
		drop_m = drop_port_in[cur_r.src] || drop_port_eg[c_port] ||
			cur_r.drop_mode;
		limit_hit = limit_on_r && (copies_r >= lim_max_r);
		mirror_kill = is_mirror && discarded_r && !mirror_on_discard;
		allowed = (sheet_ok[0] || sheet_ok[1]) &&
			(sheet_ok[2] || sheet_ok[3]);
		step = busy_r && any_pend && !rel_valid;
		do_lim = step && !mirror_kill && limit_hit;
		do_enq = step && !mirror_kill && !limit_hit && allowed;
		do_drop = step && (mirror_kill || (!limit_hit && !allowed &&
			drop_m));
		stall = step && !mirror_kill && !limit_hit && !allowed && !drop_m;
		pend_nxt = pend_r;
		if (step && !stall)
			pend_nxt[sel] = 1'b0;
		frame_done = busy_r && (pend_nxt == '0);
	end

	////////////////////////////////////////////////////////////////////
	// frame take and copy progress
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			frm_ready <= 1'b0;
			pend_r <= '0;
			cur_r <= '0;
			copies_r <= '0;
			limit_on_r <= 1'b0;
			lim_max_r <= '0;
			discarded_r <= 1'b0;
			first_r <= 1'b0;
		end else if (take) begin
			busy_r <= 1'b1;
			frm_ready <= 1'b0;
			pend_r <= take_pend;
			cur_r <= frm;
			copies_r <= '0;
			limit_on_r <= ingress_queue_size[frm.src] >
				copy_limit_cfg[frm.src].thr;
			lim_max_r <= copy_limit_cfg[frm.src].max_copies;
			discarded_r <= 1'b0;
			first_r <= 1'b1;
		end else begin
			pend_r <= pend_nxt;
			frm_ready <= !busy_r || frame_done;
			busy_r <= busy_r && !frame_done;
			if (do_enq) begin
				copies_r <= copies_r + 1'b1;
				first_r <= 1'b0;
			end
			if (do_lim || do_drop)
				discarded_r <= 1'b1;
		end
	end

	// transmit request towards the egress queues
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			enq_valid <= 1'b0;
			enq <= '0;
			blocked <= 1'b0;
		end else begin
			enq_valid <= do_enq;
			blocked <= stall;
			if (do_enq) begin
				enq.port <= c_port;
				enq.qos <= c_qos;
				enq.super_prio <= c_sp;
				enq.drop_precedence <= cur_r.drop_precedence;
				enq.src <= cur_r.src;
				enq.words <= cur_r.words;
			end
		end
	end

	// common forward-pressure discard counter
	always_ff @(posedge sys_clk) begin
		if (rst)
			copy_limit_discard_count <= '0;
		else if (do_lim)
			copy_limit_discard_count <= copy_limit_discard_count + 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// ingress queue sizes and pfc sheet, one per port
	for (genvar p = 0; p < NPORT; p++) begin : g_port
		fcc_cnt_type pfc_r;
		assign done_vec[p] = frame_done && (cur_r.src == p);
		always_ff @(posedge sys_clk) begin
			if (rst)
				ingress_queue_size[p] <= '0;
			else if (iq_push[p] && !done_vec[p])
				ingress_queue_size[p] <= ingress_queue_size[p] + 1'b1;
			else if (!iq_push[p] && done_vec[p])
				ingress_queue_size[p] <= ingress_queue_size[p] - 1'b1;
		end
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				pfc_r <= '0;
				pfc_pause[p] <= 1'b0;
			end else begin
				if (do_enq && first_r && cur_r.src == p)
					pfc_r <= pfc_r + `FCC_CNT_W'(cur_r.words);
				else if (rel_valid && rel.last && rel.src == p)
					pfc_r <= pfc_r - `FCC_CNT_W'(rel.words);
				pfc_pause[p] <= pfc_r > pfc_thr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// four accounting sheets: 0 in words, 1 eg words, 2 in refs, 3 eg refs
	for (genvar s = 0; s < 4; s++) begin : g_sheet
		fcc_cnt_type c_pq [NPORT*NQ];
		fcc_cnt_type c_p [NPORT];
		fcc_cnt_type c_q [NQ];
		fcc_cnt_type c_s, amt, ramt, pool;
		fcc_acct_type cv, rv;
		int ap, rp;
		assign pool = (s < 2) ? `FCC_POOL_WORDS : `FCC_POOL_REFS;
		always_comb begin
			ap = (s % 2 == 0) ? int'(cur_r.src) : int'(c_port);
			rp = (s % 2 == 0) ? int'(rel.src) : int'(rel.dst);
			cv = {c_s, c_q[c_qos], c_p[ap], c_pq[ap*NQ + int'(c_qos)]};
			rv = {c_s, c_q[rel.qos], c_p[rp], c_pq[rp*NQ + int'(rel.qos)]};
			amt = fcc_cnt_type'(1'b1);
			ramt = fcc_cnt_type'(1'b1);
			if (s == 0) begin
				amt = first_r ? `FCC_CNT_W'(cur_r.words) : '0; // stored once
				ramt = rel.last ? `FCC_CNT_W'(rel.words) : '0;
			end else if (s == 1) begin
				amt = `FCC_CNT_W'(cur_r.words);
				ramt = `FCC_CNT_W'(rel.words);
			end
			// reservations first, shared only when they are closed
			if (cv[0] < thr_cfg[s][0] || cv[1] < thr_cfg[s][1])
				sheet_ok[s] = 1'b1;
			else
				sheet_ok[s] = (cv[2] < thr_cfg[s][2] ||
					cv[3] < thr_cfg[s][3]) && (c_s < pool);
		end
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				for (int i = 0; i < NPORT*NQ; i++)
					c_pq[i] <= '0;
				for (int i = 0; i < NPORT; i++)
					c_p[i] <= '0;
				for (int i = 0; i < NQ; i++)
					c_q[i] <= '0;
				c_s <= '0;
			end else if (do_enq) begin
				// update at the moment the reference is enqueued
				{c_s, c_q[c_qos], c_p[ap], c_pq[ap*NQ + int'(c_qos)]} <=
					acct_add(cv, thr_cfg[s], amt);
			end else if (rel_valid) begin
				{c_s, c_q[rel.qos], c_p[rp], c_pq[rp*NQ + int'(rel.qos)]} <=
					acct_sub(rv, ramt);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_step;
		step && !stall;
	endsequence
	sequence s_lim;
		step && !mirror_kill && limit_hit;
	endsequence
	property p_rate;
		s_step |=> $countones(pend_r) == $countones($past(pend_r)) - 1;
	endproperty
	a_rate: assert property (p_rate) else $error("copy not retired");
	property p_limit;
		s_lim |=> !enq_valid && copy_limit_discard_count ==
			$past(copy_limit_discard_count) + 1;
	endproperty
	a_limit: assert property (p_limit) else $error("limit missed");
	property p_cnt;
		!$past(do_lim) |-> $stable(copy_limit_discard_count);
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter moved");
	property p_iq;
		iq_push[0] && !done_vec[0] |=>
			ingress_queue_size[0] == $past(ingress_queue_size[0]) + 1;
	endproperty
	a_iq: assert property (p_iq) else $error("queue size wrong");
	property p_disable;
		take |=> (pend_r[NPORT +: `FCC_NCPUQ] & $past(cpu_queue_disable)) == '0;
	endproperty
	a_disable: assert property (p_disable) else $error("cpu queue leak");
	property p_admit;
		enq_valid |-> $past(allowed) && !$past(limit_hit);
	endproperty
	a_admit: assert property (p_admit) else $error("copy not allowed");
	property p_stall;
		stall |=> blocked && !enq_valid && pend_r == $past(pend_r);
	endproperty
	a_stall: assert property (p_stall) else $error("stall lost");
	property p_mirror;
		step && is_mirror && discarded_r && !mirror_on_discard |=> !enq_valid;
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror kept");
	property p_dp;
		do_enq |=> enq.drop_precedence == $past(cur_r.drop_precedence);
	endproperty
	a_dp: assert property (p_dp) else $error("dp lost");
endmodule

// >>> src/fcc_map.svh
// constants of the frame forwarder and congestion accounting block
// assumes a single 200 MHz system clock; included by the package only
`ifndef FCC_MAP_SVH
`define FCC_MAP_SVH
`define FCC_NPORT 8
`define FCC_PORT_W 3
`define FCC_NQOS 8
`define FCC_QOS_W 3
`define FCC_NCPUQ 8
`define FCC_XLAT_N 12
`define FCC_XL_MIRROR 8
`define FCC_XL_LEARN 11
`define FCC_XL_EXTRA 12
`define FCC_PROBE_W 2
`define FCC_WORDS_W 6
`define FCC_CNT_W 13
`define FCC_IQ_W 8
`define FCC_LIM_W 4
`define FCC_WORD_BYTES 176
`define FCC_POOL_WORDS 13'h1740
`define FCC_POOL_REFS 13'h1740
`define FCC_CLK_MHZ 200
`define FCC_MIN_MFPS 78
`define FCC_CYC_PER_FRAME (`FCC_CLK_MHZ / `FCC_MIN_MFPS)
`define FCC_DROPCNT_W 32
`endif

// >>> src/fcc_pkg.sv
// types shared by the forwarder: analyzer result, transmit request,
// release notice, translation entries and account vectors
// assumes fcc_map.svh is on the include path
`include "fcc_map.svh"
package fcc_pkg;
	typedef logic [`FCC_CNT_W-1:0] fcc_cnt_type;
	// account vector: 0 port-qos res, 1 port res, 2 qos share, 3 shared
	typedef logic [3:0][`FCC_CNT_W-1:0] fcc_acct_type;
	typedef struct packed {
		logic [`FCC_PORT_W-1:0] src;
		logic [`FCC_NPORT-1:0] dest_mask;
		logic [`FCC_NCPUQ-1:0] cpu_queue_mask;
		logic [`FCC_PROBE_W-1:0] mirror;
		logic learn_all;
		logic drop_mode;
		logic [1:0] drop_precedence;
		logic [`FCC_QOS_W-1:0] qos;
		logic [`FCC_WORDS_W-1:0] words;
	} fcc_frame_type;
	typedef struct packed {
		logic [`FCC_PORT_W-1:0] port;
		logic [`FCC_QOS_W-1:0] qos;
		logic super_prio;
		logic [1:0] drop_precedence;
		logic [`FCC_PORT_W-1:0] src;
		logic [`FCC_WORDS_W-1:0] words;
	} fcc_enq_type;
	typedef struct packed {
		logic [`FCC_PORT_W-1:0] src;
		logic [`FCC_PORT_W-1:0] dst;
		logic [`FCC_QOS_W-1:0] qos;
		logic [`FCC_WORDS_W-1:0] words;
		logic last;
	} fcc_rel_type;
	typedef struct packed {
		logic [`FCC_PORT_W-1:0] port;
		logic [`FCC_QOS_W-1:0] qos;
		logic follow_qos;
		logic super_prio;
	} fcc_xlate_type;
	typedef struct packed {
		logic [`FCC_IQ_W-1:0] thr;
		logic [`FCC_LIM_W-1:0] max_copies;
	} fcc_limit_type;
endpackage

// >>> test/fcc_egress_model.sv
// egress queue model: keeps transmit requests, frees them on demand
// assumes fcc_pkg compiled first; one clock, synchronous reset
module fcc_egress_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic drain,
	input wire logic enq_valid,
	input wire fcc_pkg::fcc_enq_type enq,
	output logic rel_valid,
	output fcc_pkg::fcc_rel_type rel
);
	timeunit 1ns;
	timeprecision 1ps;
	import fcc_pkg::*;
	fcc_enq_type q[$];
	fcc_enq_type h;
	int n;
	// one release every other cycle while drain is high; last copy of a
	// source frees its ingress words; idle release bus keeps toggling
	always @(posedge sys_clk) begin
		if (rst) begin
			q.delete();
			rel_valid <= 1'b0;
			rel <= '0;
		end else begin
			if (enq_valid)
				q.push_back(enq);
			if (drain && !rel_valid && q.size() > 0) begin
				h = q.pop_front();
				n = 0;
				foreach (q[i])
					if (q[i].src == h.src)
						n++;
				rel_valid <= 1'b1;
				rel <= '{h.src, h.port, h.qos, h.words, n == 0};
			end else begin
				rel_valid <= 1'b0;
				rel <= ~rel;
			end
		end
	end
endmodule

// >>> test/tb_top.sv
// bench top: drives analyzer results and config, checks requests,
// counters and status; egress model sits downstream
// assumes fcc_pkg and fcc_egress_model are compiled first
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fcc_pkg::*;
	typedef struct {fcc_frame_type f; int n;} fcc_row_type;
	localparam logic [7:0] cpu_dis = 8'h04;
	logic sys_clk, rst, frm_valid, frm_ready, enq_valid, blocked;
	logic rel_valid, drain, mirror_on_discard, stack2;
	fcc_frame_type frm, f;
	fcc_enq_type enq;
	fcc_rel_type rel;
	logic [7:0] iq_push, drop_port_in, drop_port_eg, pfc_pause;
	logic [7:0] ingress_queue_size [8];
	fcc_limit_type copy_limit_cfg [8];
	logic [31:0] copy_limit_discard_count, c0;
	fcc_xlate_type xlate_cfg [12];
	fcc_acct_type thr_cfg [4];
	fcc_cnt_type pfc_thr;
	fcc_enq_type got[$], expq[$];
	fcc_row_type rows [8];
	int bad_count, num_checks, cyc, t0;

	fcc_forwarder #(.NPORT(8)) dut_u (.sys_clk(sys_clk), .rst(rst),
		.frm_valid(frm_valid), .frm(frm), .frm_ready(frm_ready),
		.enq_valid(enq_valid), .enq(enq), .blocked(blocked),
		.rel_valid(rel_valid), .rel(rel), .iq_push(iq_push),
		.ingress_queue_size(ingress_queue_size),
		.copy_limit_cfg(copy_limit_cfg),
		.copy_limit_discard_count(copy_limit_discard_count),
		.xlate_cfg(xlate_cfg), .extra_stack_en(stack2),
		.extra_stack_port(3'h7), .cpu_queue_disable(cpu_dis),
		.mirror_on_discard(mirror_on_discard),
		.drop_port_in(drop_port_in), .drop_port_eg(drop_port_eg),
		.thr_cfg(thr_cfg), .pfc_thr(pfc_thr), .pfc_pause(pfc_pause));
	fcc_egress_model eg_u (.sys_clk(sys_clk), .rst(rst), .drain(drain),
		.enq_valid(enq_valid), .enq(enq), .rel_valid(rel_valid),
		.rel(rel));

	////////////////////////////////////////////////////////////////////
	// clock, cycle count and request capture
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (enq_valid === 1'b1)
			got.push_back(enq);
	end

	////////////////////////////////////////////////////////////////////
	// helpers
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic test_done();
		if (bad_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic fcc_frame_type mk(int s, d, c, m, l, dm, dp);
		mk = '{3'(s), 8'(d), 8'(c), 2'(m), 1'(l), 1'(dm), 2'(dp),
			~3'(s), 6'(s + 5)};
	endfunction
	function automatic fcc_enq_type tx(fcc_frame_type x, int i);
		fcc_xlate_type t;
		t = xlate_cfg[i];
		tx = '{t.port, (i < 8 && t.follow_qos) ? x.qos : t.qos,
			t.super_prio, x.drop_precedence, x.src, x.words};
	endfunction
	// expected copies in order: ports, cpu queues, probe, stack links
	task automatic exp_build(fcc_frame_type x);
		fcc_enq_type e;
		e = '{3'h0, x.qos, 1'b0, x.drop_precedence, x.src, x.words};
		for (int p = 0; p < 8; p++) begin
			e.port = 3'(p);
			if (x.dest_mask[p])
				expq.push_back(e);
		end
		for (int q = 0; q < 8; q++)
			if (x.cpu_queue_mask[q] && !cpu_dis[q])
				expq.push_back(tx(x, q));
		if (x.mirror != 2'h0)
			expq.push_back(tx(x, 7 + int'(x.mirror)));
		if (x.learn_all)
			expq.push_back(tx(x, 11));
		e.port = 3'h7;
		if (x.learn_all && stack2)
			expq.push_back(e);
	endtask
	// push to the ingress queue, then offer the frame until taken
	task automatic send(fcc_frame_type x, fcc_frame_type xe);
		got.delete();
		expq.delete();
		exp_build(xe);
		@(posedge sys_clk);
		iq_push <= 8'h01 << x.src;
		@(posedge sys_clk);
		iq_push <= 8'h00;
		repeat (2) @(posedge sys_clk);
		chk("queue size", ingress_queue_size[x.src], 8'h01);
		frm_valid <= 1'b1;
		frm <= x;
		@(posedge sys_clk);
		for (int w = 0; w < 2000 && frm_ready !== 1'b1; w++)
			@(posedge sys_clk);
		t0 = cyc;
		frm_valid <= 1'b0;
		frm <= ~x;
	endtask
	// wait for the frame to finish, then compare copies
	task automatic fin(bit tim);
		@(posedge sys_clk);
		#1;
		for (int w = 0; w < 2000 && frm_ready !== 1'b1; w++) begin
			@(posedge sys_clk);
			#1;
		end
		if (tim)
			chk("cycles", 32'(cyc - t0 <= expq.size() + 4), 32'h1);
		repeat (3) @(posedge sys_clk);
		for (int i = 0; i < got.size() && i < expq.size(); i++) begin
			chk("port", got[i].port, expq[i].port);
			chk("dp", got[i].drop_precedence, expq[i].drop_precedence);
			chk("src words", {got[i].src, got[i].words},
				{expq[i].src, expq[i].words});
			chk("qos sp", {got[i].qos, got[i].super_prio},
				{expq[i].qos, expq[i].super_prio});
		end
	endtask

	////////////////////////////////////////////////////////////////////
	// watchdog
	initial begin
		repeat (20000) @(posedge sys_clk);
		bad_count++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst = 1'b1;
		frm_valid = 1'b0;
		frm = '0;
		drain = 1'b0;
		mirror_on_discard = 1'b0;
		stack2 = 1'b1;
		iq_push = 8'h00;
		drop_port_in = 8'h00;
		drop_port_eg = 8'h00;
		pfc_thr = 13'h1fff;
		foreach (xlate_cfg[i])
			xlate_cfg[i] = '{3'(i) ^ 3'h5, 3'(i + 1), i[0], i == 3};
		foreach (copy_limit_cfg[i])
			copy_limit_cfg[i] = '{8'hff, 4'hf};
		foreach (thr_cfg[i])
			thr_cfg[i] = '{4{13'h1fff}};
		rows = '{'{mk(0, 8'h22, 0, 0, 0, 0, 1), 2},
			'{mk(1, 0, 8'h0f, 0, 0, 0, 0), 3}, '{mk(2, 8'h81, 0, 3, 0, 0, 2), 3},
			'{mk(3, 0, 0, 0, 1, 0, 3), 2}, '{mk(4, 0, 0, 0, 0, 0, 0), 0},
			'{mk(5, 8'hdf, 8'hf0, 1, 1, 0, 1), 14},
			'{mk(6, 0, 0, 2, 0, 0, 2), 1}, '{mk(7, 0, 8'h04, 0, 0, 1, 0), 0}};
		repeat (10) @(posedge sys_clk);
		#1;
		chk("reset outs", {frm_ready, enq_valid, pfc_pause}, 32'h0);
		chk("reset count", copy_limit_discard_count, 32'h0);
		@(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("ready after reset", frm_ready, 1'b1);
		foreach (rows[r]) begin
			send(rows[r].f, rows[r].f);
			fin(1);
			chk("copies", got.size(), rows[r].n);
			chk("queue size", ingress_queue_size[r], 8'h00);
		end
		// learn-all with the second stack link switched off
		stack2 <= 1'b0;
		@(posedge sys_clk);
		send(mk(3, 0, 0, 0, 1, 0, 1), mk(3, 0, 0, 0, 1, 0, 1));
		fin(1);
		chk("copies", got.size(), 1);
		// forward pressure: two copies allowed, mirror after a discard
		copy_limit_cfg[6] <= '{8'h00, 4'h2};
		for (int m = 0; m < 2; m++) begin
			mirror_on_discard <= m[0];
			c0 = copy_limit_discard_count;
			send(mk(6, 8'h0b, 0, 1, 0, 0, 2), mk(6, 8'h03, 0, 0, 0, 0, 2));
			fin(0);
			chk("copies", got.size(), 2);
			chk("discards", copy_limit_discard_count, c0 + 1 + m);
		end
		// congestion: port-qos reservation of 3 words, other word accounts closed
		copy_limit_cfg[6] <= '{8'hff, 4'hf};
		drain <= 1'b1;
		repeat (150) @(posedge sys_clk);
		drain <= 1'b0;
		thr_cfg[0] <= '{13'h0, 13'h0, 13'h0, 13'h3};
		thr_cfg[1] <= '{13'h0, 13'h0, 13'h0, 13'h3};
		pfc_thr <= 13'h4;
		f = mk(0, 8'h02, 0, 0, 0, 1, 3);
		send(f, f);
		fin(0);
		chk("copies", got.size(), 1);
		chk("pause", pfc_pause[0], 1'b1);
		f.drop_mode = 1'b0;
		drop_port_in <= 8'h01;
		send(f, '0);
		fin(0);
		chk("copies", got.size(), 0);
		drop_port_in <= 8'h00;
		drop_port_eg <= 8'h02;
		send(f, '0);
		fin(0);
		chk("copies", got.size(), 0);
		drop_port_eg <= 8'h00;
		send(f, f);
		repeat (10) @(posedge sys_clk);
		chk("stall", {blocked, frm_ready}, 2'b10);
		chk("copies", got.size(), 0);
		drain <= 1'b1;
		fin(0);
		chk("copies", got.size(), 1);
		repeat (20) @(posedge sys_clk);
		chk("pause", pfc_pause[0], 1'b0);
		test_done();
	end
endmodule
